// >>> verification/keyed_sequence_watchdog_bench.sv
`include "kswd_map.vh"
module keyed_sequence_watchdog_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // Short counter keeps every timeout under a few hundred cycles
  localparam int CW = 4;
  logic clock_i, srst_i, ce, awv, wv, br, arv, rr, sfw, pd, crst_d;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdd, cnt0;
  logic [3:0] system_timer_prescale;
  logic [1:0] rsp;
  wire awr, wrdy, bv, arr, rv, crst, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  int err_total, tests_run, rst_cnt, exp_rst, cyc, n;
  kswd_top #(.CNT_W(CW)) u_dut (.clock_i(clock_i), .srst_i(srst_i), .ce_i(ce),
    .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr),
    .sfr_write_i(sfw), .power_down_i(pd), .idle_i(1'b0), .system_timer_prescale_i(system_timer_prescale),
    .core_reset_o(crst), .irq_o(irq));
  initial begin
    clock_i = 0;
    forever #5 clock_i = ~clock_i;
  end
  task results;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Rising edges of the core reset, and the hang guard
  always @(posedge clock_i) begin
    crst_d <= crst;
    if (crst === 1'b1 && crst_d !== 1'b1) rst_cnt <= rst_cnt + 1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    awa <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
    do begin
      @(posedge clock_i);
      if (awv && awr) awv <= 0;
      if (wv && wrdy) wv <= 0;
    end while (!(bv === 1'b1 && br));
    rsp = bresp;
    br <= 0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clock_i);
    ara <= a; arv <= 1; rr <= 1;
    do begin
      @(posedge clock_i);
      if (arv && arr) arv <= 0;
    end while (!(rv === 1'b1 && rr));
    rdd = rdata;
    rsp = rresp;
    rr <= 0;
  endtask
  task key(input logic [7:0] b);
    wr(`KSWD_OFF_KEY, {24'h0, b});
  endtask
  task rchk;
    repeat (3) @(posedge clock_i);
    chk(rst_cnt, exp_rst);
  endtask
  // Reset is counted from the end of the enabling write, so allow a few cycles of slack
  task tmo(input int p);
    n = 0;
    while (crst !== 1'b1 && n < 3000) begin
      @(posedge clock_i);
      n++;
    end
    chk({31'h0, n >= p - 3 && n <= p + 4}, 32'h1);
    exp_rst++;
  endtask
  initial begin
    srst_i = 1; ce = 1; awv = 0; wv = 0; br = 0; arv = 0; rr = 0; sfw = 0; pd = 0;
    awa = 0; ara = 0; wd = 0; system_timer_prescale = 0; crst_d = 0;
    rst_cnt = 0; exp_rst = 0; cyc = 0; err_total = 0; tests_run = 0;
    repeat (16) @(posedge clock_i);
    srst_i <= 0;
    rd(`KSWD_OFF_CTRL); chk(rdd, 32'h0);
    chk({31'h0, irq}, 32'h0);
    rd(8'h20); chk({30'h0, rsp}, 32'h2);
    wr(8'h20, 32'h0); chk({30'h0, rsp}, 32'h2);
    @(posedge clock_i) ce <= 0;
    repeat (3) @(posedge clock_i);
    ce <= 1;
    $display("test bus done");
    wr(`KSWD_OFF_IRQ_MASK, 32'h4);
    key(8'h5A); key(8'hA5); exp_rst++; rchk;
    rd(`KSWD_OFF_CTRL); chk(rdd, 32'h4);
    chk({31'h0, irq}, 32'h1);
    rd(`KSWD_OFF_IRQ_STAT); chk(rdd & 32'h4, 32'h4);
    repeat (2) @(posedge clock_i);
    chk({31'h0, irq}, 32'h0);
    wr(`KSWD_OFF_IRQ_MASK, 32'h0);
    $display("test soft reset done");
    // Period 1 steps the count every other cycle, so a missed freeze shows in 30 cycles
    wr(`KSWD_OFF_CTRL, 32'h20);
    key(8'h1E); rd(`KSWD_OFF_CTRL); key(8'hE1);
    rd(`KSWD_OFF_CTRL); chk(rdd, 32'h21);
    @(posedge clock_i) pd <= 1;
    rd(`KSWD_OFF_COUNT); cnt0 = rdd;
    repeat (30) @(posedge clock_i);
    rd(`KSWD_OFF_COUNT); chk(rdd, cnt0);
    pd <= 0;
    key(8'h1E); key(8'h33); exp_rst++; rchk;
    rd(`KSWD_OFF_CTRL); chk(rdd, 32'h26);
    wr(`KSWD_OFF_CTRL, 32'hE0); key(8'h1E);
    @(posedge clock_i) sfw <= 1;
    @(posedge clock_i) sfw <= 0;
    key(8'hE1); exp_rst++; rchk;
    rd(`KSWD_OFF_CTRL); chk(rdd, 32'hE6);
    $display("test key sequence done");
    for (int ps = 0; ps < 3; ps++) begin
      wr(`KSWD_OFF_CTRL, ps << 5);
      @(posedge clock_i) system_timer_prescale <= ps[3:0];
      key(8'h1E); key(8'hE1);
      tmo((ps + 1) << (ps + CW)); rchk;
    end
    wr(`KSWD_OFF_CTRL, 32'h40);
    @(posedge clock_i) system_timer_prescale <= 4'h1;
    key(8'h1E); key(8'hE1);
    repeat (4) begin
      repeat (90) @(posedge clock_i);
      key(8'h1E); key(8'hE1);
    end
    chk(rst_cnt, exp_rst);
    tmo(128); rchk;
    rd(`KSWD_OFF_CTRL); chk(rdd, 32'h42);
    $display("test period done");
    results();
  end
endmodule // keyed_sequence_watchdog_bench
bind kswd_top kswd_monitor #(.ADDR_W(ADDR_W)) u_mon (.clock_i(clock_i), .srst_i(srst_i),
  .ce_i(ce_i), .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
  .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
  .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i), .core_reset_o(core_reset_o), .irq_o(irq_o));

// >>> verification/kswd_monitor.sv
module kswd_monitor #(
  parameter ADDR_W = 8
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // Bus
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Results
  input wire logic core_reset_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  a_reset_clean_out: assert property ($fell(srst_i) |-> !core_reset_o && !irq_o
    && !s_axi_bvalid_o && !s_axi_rvalid_o) else $error("outputs not clear after reset");
  a_core_pulse_len: assert property ($rose(core_reset_o) |-> core_reset_o [*4])
    else $error("core reset pulse too short");
  a_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read data dropped");
  a_write_block: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write accepted during response");
  a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
    && s_axi_wready_o |-> ##[1:2] s_axi_bvalid_o) else $error("write answer late");
  a_bad_addr: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
    && s_axi_wready_o && s_axi_awaddr_i > 8'h10 |-> ##[1:2] (s_axi_bvalid_o
    && s_axi_bresp_o == 2'h2)) else $error("unmapped write not refused");
  a_ce_freeze: assert property (!ce_i |-> !s_axi_awready_o && !s_axi_wready_o
    && !s_axi_arready_o) else $error("ready while clock enable low");
endmodule // kswd_monitor

// >>> verilog/kswd_map.vh
`ifndef KSWD_MAP_VH
`define KSWD_MAP_VH

// Register byte offsets
`define KSWD_OFF_CTRL 8'h00
`define KSWD_OFF_KEY 8'h04
`define KSWD_OFF_IRQ_STAT 8'h08
`define KSWD_OFF_IRQ_MASK 8'h0C
`define KSWD_OFF_COUNT 8'h10

// Control register fields
`define KSWD_CTRL_PS_LSB 5
`define KSWD_CTRL_PS_MSB 7
`define KSWD_CTRL_IDLE_BIT 4
`define KSWD_CTRL_SOFT_RESET_FLAG_BIT 2
`define KSWD_CTRL_OVF_BIT 1
`define KSWD_CTRL_RUN_BIT 0

// Interrupt status and mask fields
`define KSWD_IRQ_TIMEOUT_BIT 0
`define KSWD_IRQ_BADKEY_BIT 1
`define KSWD_IRQ_SOFT_BIT 2
`define KSWD_IRQ_FEED_BIT 3

// Reset values
`define KSWD_PS_RST 3'h0
`define KSWD_IRQ_MASK_RST 4'h0

// Key bytes
`define KSWD_KEY_FEED_FIRST 8'h1E
`define KSWD_KEY_FEED_SECOND 8'hE1
`define KSWD_KEY_SOFT_FIRST 8'h5A
`define KSWD_KEY_SOFT_SECOND 8'hA5

// Counts and bus response codes
`define KSWD_CORE_RESET_CYCLES 3'h4
`define KSWD_AXI_OKAY 2'h0
`define KSWD_AXI_SLVERR 2'h2

`endif

// >>> verilog/kswd_timer.v
module kswd_timer #(
  parameter CNT_W = 14,
  parameter PRE_W = 7,
  parameter TPS_W = 4,
  parameter PS_W = 3
) (
  // Clock and control
  input wire clock_i,
  input wire srst_i,
  input wire ce_i,
  input wire run_i,
  input wire clear_i,
  // Period setup
  input wire [PS_W-1:0] period_sel_i,
  input wire [TPS_W-1:0] tps_i,
  // Result
  output reg timeout_o,
  output wire [CNT_W-1:0] count_o
);

  reg [TPS_W-1:0] tps_cnt_reg;
  reg [PRE_W-1:0] pre_reg;
  reg [CNT_W-1:0] cnt_reg;
  wire base_tick;
  wire [PRE_W-1:0] ps_mask;
  wire stage_tick;

  // Greater-or-equal so a lowered divisor cannot strand the count
  assign base_tick = run_i && (tps_cnt_reg >= tps_i);
  assign ps_mask = ~({PRE_W{1'b1}} << period_sel_i);
  assign stage_tick = base_tick && ((pre_reg & ps_mask) == ps_mask);
  assign count_o = cnt_reg;

  always @(posedge clock_i) begin
    if (srst_i) begin
      tps_cnt_reg <= {TPS_W{1'b0}};
      pre_reg <= {PRE_W{1'b0}};
      cnt_reg <= {CNT_W{1'b0}};
      timeout_o <= 1'b0;
    end else if (ce_i) begin
      timeout_o <= stage_tick && (&cnt_reg);
      if (clear_i) begin
        tps_cnt_reg <= {TPS_W{1'b0}};
        pre_reg <= {PRE_W{1'b0}};
        cnt_reg <= {CNT_W{1'b0}};
      end else if (run_i) begin
        tps_cnt_reg <= base_tick ? {TPS_W{1'b0}} : tps_cnt_reg + 1'b1;
        if (base_tick) begin
          pre_reg <= pre_reg + 1'b1;
        end
        if (stage_tick) begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
    end
  end

endmodule // kswd_timer

// >>> verilog/kswd_top.v
// Local design decisions: register access over AXI4-Lite and the register addresses.
`include "kswd_map.vh"

module kswd_top #(
  parameter ADDR_W = 8,
  parameter CNT_W = 14,
  parameter PRE_W = 7,
  parameter TPS_W = 4
) (
  // Clock, reset, enable
  input wire clock_i,
  input wire srst_i,
  input wire ce_i,
  // AXI4-Lite write address and data
  input wire [ADDR_W-1:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output wire s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output wire s_axi_wready_o,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  // AXI4-Lite read
  input wire [ADDR_W-1:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output wire s_axi_arready_o,
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  // Processor side
  input wire sfr_write_i,
  input wire power_down_i,
  input wire idle_i,
  input wire [TPS_W-1:0] system_timer_prescale_i,
  // Results
  output reg core_reset_o,
  output reg irq_o
);

  localparam SEL_NONE = 3'd0;
  localparam SEL_CTRL = 3'd1;
  localparam SEL_KEY = 3'd2;
  localparam SEL_STAT = 3'd3;
  localparam SEL_MASK = 3'd4;
  localparam SEL_COUNT = 3'd5;

  localparam KS_IDLE = 2'd0;
  localparam KS_FEED = 2'd1;
  localparam KS_SOFT = 2'd2;

  function [2:0] reg_sel;
    input [ADDR_W-1:0] addr;
    begin
      if (addr == `KSWD_OFF_CTRL) begin
        reg_sel = SEL_CTRL;
      end else if (addr == `KSWD_OFF_KEY) begin
        reg_sel = SEL_KEY;
      end else if (addr == `KSWD_OFF_IRQ_STAT) begin
        reg_sel = SEL_STAT;
      end else if (addr == `KSWD_OFF_IRQ_MASK) begin
        reg_sel = SEL_MASK;
      end else if (addr == `KSWD_OFF_COUNT) begin
        reg_sel = SEL_COUNT;
      end else begin
        reg_sel = SEL_NONE;
      end
    end
  endfunction

  // Bus holding registers
  reg aw_held_reg;
  reg [ADDR_W-1:0] aw_addr_reg;
  reg w_held_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;

  // Control and status state
  reg [2:0] period_sel_reg;
  reg idle_freeze_reg;
  reg soft_reset_flag_reg;
  reg watchdog_overflow_flag_reg;
  reg watchdog_running_flag_reg;
  reg [3:0] irq_stat_reg;
  reg [3:0] irq_mask_reg;
  reg [1:0] key_state_reg;
  reg [2:0] core_rst_cnt_reg;

  // Next values
  reg [1:0] key_state_next;
  reg feed_ok;
  reg soft_ok;
  reg bad_key;
  reg soft_reset_flag_next;
  reg watchdog_overflow_flag_next;
  reg watchdog_running_flag_next;
  reg [3:0] irq_stat_next;
  reg [3:0] irq_mask_next;
  reg [31:0] rdata_next;

  wire wr_fire;
  wire [2:0] wr_sel;
  wire [2:0] rd_sel;
  wire rd_fire;
  wire key_wr;
  wire other_wr;
  wire ctrl_wr;
  wire [7:0] key_byte;
  wire timer_run;
  wire timer_clear;
  wire timeout;
  wire fire_reset;
  wire [3:0] irq_events;
  wire [CNT_W-1:0] count_val;

  // One write at a time; ce low stalls every handshake
  assign s_axi_awready_o = ce_i && !aw_held_reg && !s_axi_bvalid_o;
  assign s_axi_wready_o = ce_i && !w_held_reg && !s_axi_bvalid_o;
  assign s_axi_arready_o = ce_i && !s_axi_rvalid_o;
  assign wr_fire = ce_i && aw_held_reg && w_held_reg && !s_axi_bvalid_o;
  assign rd_fire = s_axi_arvalid_i && s_axi_arready_o;
  assign wr_sel = reg_sel(aw_addr_reg);
  assign rd_sel = reg_sel(s_axi_araddr_i);

  assign key_byte = w_data_reg[7:0];
  assign key_wr = wr_fire && (wr_sel == SEL_KEY) && w_strb_reg[0];
  assign ctrl_wr = wr_fire && (wr_sel == SEL_CTRL) && w_strb_reg[0];
  // Any write that is not a key byte counts as an intervening write
  assign other_wr = sfr_write_i || (wr_fire && !key_wr);

  // Key sequence checker
  always @* begin
    key_state_next = key_state_reg;
    feed_ok = 1'b0;
    soft_ok = 1'b0;
    bad_key = 1'b0;
    case (key_state_reg)
      KS_IDLE: begin
        if (key_wr) begin
          if (key_byte == `KSWD_KEY_FEED_FIRST) begin
            key_state_next = KS_FEED;
          end else if (key_byte == `KSWD_KEY_SOFT_FIRST) begin
            key_state_next = KS_SOFT;
          end else begin
            bad_key = 1'b1;
          end
        end
      end
      KS_FEED: begin
        if (key_wr) begin
          key_state_next = KS_IDLE;
          if (key_byte == `KSWD_KEY_FEED_SECOND) begin
            feed_ok = 1'b1;
          end else begin
            bad_key = 1'b1;
          end
        end else if (other_wr) begin
          key_state_next = KS_IDLE;
        end
      end
      KS_SOFT: begin
        if (key_wr) begin
          key_state_next = KS_IDLE;
          if (key_byte == `KSWD_KEY_SOFT_SECOND) begin
            soft_ok = 1'b1;
          end else begin
            bad_key = 1'b1;
          end
        end else if (other_wr) begin
          key_state_next = KS_IDLE;
        end
      end
      default: begin
        key_state_next = KS_IDLE;
      end
    endcase
  end

  assign fire_reset = timeout || bad_key || soft_ok;
  // Frozen in power-down, and in idle when the freeze bit asks for it
  assign timer_run = watchdog_running_flag_reg && !power_down_i
                     && !(idle_i && idle_freeze_reg);
  // A feed before the first enable also starts from zero
  assign timer_clear = feed_ok || fire_reset;

  kswd_timer #(
    .CNT_W(CNT_W),
    .PRE_W(PRE_W),
    .TPS_W(TPS_W),
    .PS_W(3)
  ) u_timer (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .run_i(timer_run),
    .clear_i(timer_clear),
    .period_sel_i(period_sel_reg),
    .tps_i(system_timer_prescale_i),
    .timeout_o(timeout),
    .count_o(count_val)
  );

  assign irq_events = {feed_ok, soft_ok, bad_key, timeout};

  // Flag updates; a hardware set wins over a software clear
  always @* begin
    watchdog_running_flag_next = watchdog_running_flag_reg;
    if (fire_reset) begin
      watchdog_running_flag_next = 1'b0;
    end else if (feed_ok) begin
      watchdog_running_flag_next = 1'b1;
    end
    soft_reset_flag_next = soft_reset_flag_reg;
    if (ctrl_wr && !w_data_reg[`KSWD_CTRL_SOFT_RESET_FLAG_BIT]) begin
      soft_reset_flag_next = 1'b0;
    end
    if (soft_ok || bad_key) begin
      soft_reset_flag_next = 1'b1;
    end
    watchdog_overflow_flag_next = watchdog_overflow_flag_reg;
    if (ctrl_wr && !w_data_reg[`KSWD_CTRL_OVF_BIT]) begin
      watchdog_overflow_flag_next = 1'b0;
    end
    if (timeout || bad_key) begin
      watchdog_overflow_flag_next = 1'b1;
    end
    irq_mask_next = irq_mask_reg;
    if (wr_fire && (wr_sel == SEL_MASK) && w_strb_reg[0]) begin
      irq_mask_next = w_data_reg[3:0];
    end
    if (rd_fire && (rd_sel == SEL_STAT)) begin
      irq_stat_next = irq_events;
    end else begin
      irq_stat_next = irq_stat_reg | irq_events;
    end
  end

  // Read data mux
  always @* begin
    rdata_next = 32'h0000_0000;
    if (rd_sel == SEL_CTRL) begin
      rdata_next[`KSWD_CTRL_PS_MSB:`KSWD_CTRL_PS_LSB] = period_sel_reg;
      rdata_next[`KSWD_CTRL_IDLE_BIT] = idle_freeze_reg;
      rdata_next[`KSWD_CTRL_SOFT_RESET_FLAG_BIT] = soft_reset_flag_reg;
      rdata_next[`KSWD_CTRL_OVF_BIT] = watchdog_overflow_flag_reg;
      rdata_next[`KSWD_CTRL_RUN_BIT] = watchdog_running_flag_reg;
    end else if (rd_sel == SEL_STAT) begin
      rdata_next[3:0] = irq_stat_reg;
    end else if (rd_sel == SEL_MASK) begin
      rdata_next[3:0] = irq_mask_reg;
    end else if (rd_sel == SEL_COUNT) begin
      rdata_next[CNT_W-1:0] = count_val;
    end
  end

  // Bus channel state
  always @(posedge clock_i) begin
    if (srst_i) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= {ADDR_W{1'b0}};
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `KSWD_AXI_OKAY;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rresp_o <= `KSWD_AXI_OKAY;
      s_axi_rdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_i;
        w_strb_reg <= s_axi_wstrb_i;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        // Read-only registers answer OKAY and ignore the data
        s_axi_bresp_o <= (wr_sel == SEL_NONE) ? `KSWD_AXI_SLVERR : `KSWD_AXI_OKAY;
      end else if (s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
      if (rd_fire) begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o <= rdata_next;
        s_axi_rresp_o <= (rd_sel == SEL_NONE) ? `KSWD_AXI_SLVERR : `KSWD_AXI_OKAY;
      end else if (s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

  // Watchdog control state
  always @(posedge clock_i) begin
    if (srst_i) begin
      period_sel_reg <= `KSWD_PS_RST;
      idle_freeze_reg <= 1'b0;
      soft_reset_flag_reg <= 1'b0;
      watchdog_overflow_flag_reg <= 1'b0;
      watchdog_running_flag_reg <= 1'b0;
      irq_stat_reg <= 4'h0;
      irq_mask_reg <= `KSWD_IRQ_MASK_RST;
      key_state_reg <= KS_IDLE;
      core_rst_cnt_reg <= 3'h0;
      core_reset_o <= 1'b0;
      irq_o <= 1'b0;
    end else if (ce_i) begin
      if (ctrl_wr) begin
        period_sel_reg <= w_data_reg[`KSWD_CTRL_PS_MSB:`KSWD_CTRL_PS_LSB];
        idle_freeze_reg <= w_data_reg[`KSWD_CTRL_IDLE_BIT];
      end
      soft_reset_flag_reg <= soft_reset_flag_next;
      watchdog_overflow_flag_reg <= watchdog_overflow_flag_next;
      watchdog_running_flag_reg <= watchdog_running_flag_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      irq_o <= |(irq_stat_next & irq_mask_next);
      // The core is held in reset, so a half-entered key pair is dropped
      key_state_reg <= fire_reset ? KS_IDLE : key_state_next;
      // Fixed-width pulse; a new cause restarts it
      if (fire_reset) begin
        core_rst_cnt_reg <= `KSWD_CORE_RESET_CYCLES;
        core_reset_o <= 1'b1;
      end else if (core_rst_cnt_reg != 3'h0) begin
        core_rst_cnt_reg <= core_rst_cnt_reg - 1'b1;
        core_reset_o <= (core_rst_cnt_reg != 3'h1);
      end else begin
        core_reset_o <= 1'b0;
      end
    end
  end

endmodule // kswd_top
